// [design/dcl_regs.svh]
`ifndef DCL_REGS_SVH
`define DCL_REGS_SVH
// ==========================================
// Register offsets (byte addresses)
`define DCL_OFF_CTRL 8'h00
`define DCL_OFF_VICT 8'h04
`define DCL_OFF_MARG 8'h08
`define DCL_OFF_MCMD 8'h0c
`define DCL_OFF_STAT 8'h10
// ==========================================
// Field positions and reset values
`define DCL_CTRL_EN 0
`define DCL_CTRL_ORDER 14
`define DCL_VICT_LSB 26
`define DCL_STAT_BUSY 0
`define DCL_STAT_HIT 1
`define DCL_LFSR_RST 6'h2d
`define DCL_LAST_IDX 6'h3f
`define DCL_LAST_WORD 3'h7
`endif

// [design/dcl_pkg.sv]
`default_nettype none
package dcl_pkg;
  typedef enum {ST_IDLE, ST_DRAIN, ST_BUS_RD, ST_FILL, ST_STORE, ST_BUS_WR, ST_RESP, ST_MDONE} dcl_state_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_INV_ALL = 3'h1, OP_INV_ADR = 3'h2, OP_CLN_ADR = 3'h3,
    OP_CLI_ADR = 3'h4, OP_CLN_IDX = 3'h5, OP_CLI_IDX = 3'h6
  } dcl_op_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} dcl_size_t;
endpackage
`default_nettype wire

// [design/dcl_ctl_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface dcl_ctl_if import dcl_pkg::*; ();
  logic enable, robin, vict_wr, fill_adv, idx_set, mgo, mdone, hit;
  logic [5:0] vict_val, base, victim, idx_val;
  logic [2:0] fill_seg, idx_seg;
  dcl_op_t mop;
  logic [31:0] marg;
  modport regs(output enable, robin, vict_wr, vict_val, mgo, mop, marg, input base, mdone, hit);
  modport vict(input robin, vict_wr, vict_val, fill_seg, fill_adv, idx_set, idx_seg, idx_val, output victim, base);
  modport core(input enable, mgo, mop, marg, victim, output fill_seg, fill_adv, idx_set, idx_seg, idx_val, mdone,
    hit);
endinterface
`default_nettype wire

// [design/dcl_apb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcl_regs.svh"
module dcl_apb import dcl_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  dcl_ctl_if.regs ctl
);
  logic acc, known;
  logic [31:0] rd;
  assign acc = psel_in && penable_in && pready_out;
  always_comb begin
    known = 1'b1;
    unique case (paddr_in)
      `DCL_OFF_CTRL: rd = (32'(ctl.robin) << `DCL_CTRL_ORDER) | (32'(ctl.enable) << `DCL_CTRL_EN);
      `DCL_OFF_VICT: rd = 32'(ctl.base) << `DCL_VICT_LSB;
      `DCL_OFF_MARG: rd = ctl.marg;
      `DCL_OFF_MCMD: rd = 32'(ctl.mop);
      `DCL_OFF_STAT: rd = (32'(ctl.hit) << `DCL_STAT_HIT) | (32'(ctl.mgo) << `DCL_STAT_BUSY);
      default: begin
        rd = 32'h0;
        known = 1'b0;
      end
    endcase
  end
  // ==========================================
  // Answer is prepared in the setup cycle so every access costs one wait-free access phase
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      prdata_out <= (psel_in && !penable_in && !pwrite_in) ? rd : 32'h0;
      pslverr_out <= psel_in && !penable_in && !known;
    end
  end
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctl.enable <= 1'b0;
      ctl.robin <= 1'b0;
      ctl.vict_wr <= 1'b0;
      ctl.vict_val <= 6'h0;
      ctl.marg <= 32'h0;
      ctl.mop <= OP_NONE;
    end else begin
      ctl.vict_wr <= acc && pwrite_in && paddr_in == `DCL_OFF_VICT;
      if (acc && pwrite_in) begin
        if (paddr_in == `DCL_OFF_CTRL) begin
          ctl.enable <= pwdata_in[`DCL_CTRL_EN];
          ctl.robin <= pwdata_in[`DCL_CTRL_ORDER];
        end
        if (paddr_in == `DCL_OFF_VICT) ctl.vict_val <= pwdata_in[`DCL_VICT_LSB +: 6];
        if (paddr_in == `DCL_OFF_MARG) ctl.marg <= pwdata_in;
        if (paddr_in == `DCL_OFF_MCMD) ctl.mop <= dcl_op_t'(pwdata_in[2:0]);
      end
    end
  end
  // Command set wins over the done of the previous one
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) ctl.mgo <= 1'b0;
    else if (acc && pwrite_in && paddr_in == `DCL_OFF_MCMD) ctl.mgo <= 1'b1;
    else if (ctl.mdone) ctl.mgo <= 1'b0;
  end
endmodule
`default_nettype wire

// [design/dcl_victim.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcl_regs.svh"
module dcl_victim import dcl_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  dcl_ctl_if.vict ctl
);
  logic [5:0] ptr [8];
  logic [5:0] base, lfsr, cur, rnd;
  // ==========================================
  // Pointers below the base are lifted to it so locked lines stay put
  assign cur = (ptr[ctl.fill_seg] < base) ? base : ptr[ctl.fill_seg];
  assign rnd = (lfsr < base) ? base : lfsr;
  assign ctl.victim = ctl.robin ? cur : rnd;
  assign ctl.base = base;
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) lfsr <= `DCL_LFSR_RST;
    else lfsr <= {lfsr[4:0], lfsr[5] ^ lfsr[4]};
  end
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) base <= 6'h0;
    else if (ctl.vict_wr) base <= ctl.vict_val;
  end
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int s = 0; s < 8; s++) ptr[s] <= 6'h0;
    end else if (ctl.vict_wr) begin
      for (int s = 0; s < 8; s++) ptr[s] <= ctl.vict_val;
    end else begin
      if (ctl.idx_set) ptr[ctl.idx_seg] <= ctl.idx_val;
      if (ctl.fill_adv && ctl.robin) ptr[ctl.fill_seg] <= (cur == `DCL_LAST_IDX) ? base : cur + 6'h01;
    end
  end
endmodule
`default_nettype wire

// [design/dcl_cache.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcl_regs.svh"
// Functional notes
// - Eight segments, 64 lines, eight words
// - Line named by segment and index
// - Segment taken from address bits 7..5
// - Word, halfword and byte select
// - Linefill stores address bits 31..8 tag
// - Hit needs valid line with equal tag
// - Control bit 14 picks round-robin, reset random
// - Round-robin steps separately per segment
// - Cached swap is load then store, unlocked
// - No interrupt between cached swap halves
// - Uncached swap drains buffer, then reads
// - Uncached swap write unbuffered, core stalls
// - Bus lock held over uncached swap
// - Enabled cacheable load miss fills eight words
// - Linefill writes victim pointer entry
// - Victim register write loads pointer
// - Fills stay between base and 63
// - Victim field starts at bit 26
// - Six maintenance operations supported
// - Index clean moves pointer, address clean not
module dcl_cache import dcl_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic core_req_in,
  input wire logic [31:0] core_addr_in,
  input wire logic core_write_in,
  input wire logic core_swap_in,
  input wire logic [1:0] core_size_in,
  input wire logic [31:0] core_wdata_in,
  input wire logic core_cacheable_in,
  input wire logic core_bufferable_in,
  output logic core_done_out,
  output logic [31:0] core_rdata_out,
  output logic irq_hold_out,
  output logic bus_req_out,
  output logic bus_write_out,
  output logic [31:0] bus_addr_out,
  output logic [31:0] bus_wdata_out,
  output logic [1:0] bus_size_out,
  output logic bus_buf_out,
  output logic bus_lock_out,
  input wire logic bus_ack_in,
  input wire logic [31:0] bus_rdata_in,
  output logic wb_drain_out,
  input wire logic wb_empty_in
);
  dcl_ctl_if ctl();
  dcl_state_t state;
  logic [31:0] a, wd;
  logic [1:0] sz;
  logic wr, sw, cen, bf, st_hit;
  logic [5:0] lidx, lk_idx;
  logic [2:0] cnt, lk_seg;
  logic [31:0] lk_a;
  logic lk_hit, mt, fill_end;
  // Storage: 512 tagged lines of eight words each
  logic [511:0] valid_q;
  logic [23:0] tag_q [512];
  logic [31:0] data_q [4096];

  dcl_apb u_apb (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .pready_out(pready_out),
    .prdata_out(prdata_out),
    .pslverr_out(pslverr_out),
    .ctl(ctl.regs)
  );
  dcl_victim u_victim (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .ctl(ctl.vict)
  );

  // ==========================================
  // Byte lane helpers
  function automatic logic [31:0] pick(input logic [31:0] w, input logic [1:0] lo, input logic [1:0] s);
    logic [31:0] r;
    r = w;
    if (s == SZ_BYTE) r = {24'h0, w[{lo, 3'h0} +: 8]};
    else if (s == SZ_HALF) r = {16'h0, w[{lo[1], 4'h0} +: 16]};
    return r;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [1:0] lo,
                                        input logic [1:0] s);
    logic [31:0] r;
    r = n;
    if (s == SZ_BYTE) begin
      r = o;
      r[{lo, 3'h0} +: 8] = n[7:0];
    end else if (s == SZ_HALF) begin
      r = o;
      r[{lo[1], 4'h0} +: 16] = n[15:0];
    end
    return r;
  endfunction

  // ==========================================
  // Lookup: all 64 lines of one segment are compared, the index plays no part in the address
  assign mt = state == ST_IDLE && ctl.mgo;
  assign lk_a = (state != ST_IDLE) ? a : (ctl.mgo ? ctl.marg : core_addr_in);
  assign lk_seg = lk_a[7:5];
  always_comb begin
    lk_hit = 1'b0;
    lk_idx = 6'h0;
    for (int i = 0; i < 64; i++) begin
      if (valid_q[{lk_seg, 6'(i)}] && tag_q[{lk_seg, 6'(i)}] == lk_a[31:8]) begin
        lk_hit = 1'b1;
        lk_idx = 6'(i);
      end
    end
  end
  assign fill_end = state == ST_FILL && bus_ack_in && cnt == `DCL_LAST_WORD;
  assign ctl.fill_seg = (state == ST_IDLE) ? core_addr_in[7:5] : a[7:5];
  assign ctl.idx_set = mt && (ctl.mop == OP_CLN_IDX || ctl.mop == OP_CLI_IDX);
  assign ctl.idx_seg = ctl.marg[7:5];
  assign ctl.idx_val = ctl.marg[`DCL_VICT_LSB +: 6];

  // ==========================================
  // Request sequencer
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      a <= 32'h0;
      wd <= 32'h0;
      sz <= 2'h0;
      wr <= 1'b0;
      sw <= 1'b0;
      cen <= 1'b0;
      bf <= 1'b0;
      st_hit <= 1'b0;
      lidx <= 6'h0;
      cnt <= 3'h0;
      core_done_out <= 1'b0;
      core_rdata_out <= 32'h0;
      irq_hold_out <= 1'b0;
      bus_req_out <= 1'b0;
      bus_write_out <= 1'b0;
      bus_addr_out <= 32'h0;
      bus_wdata_out <= 32'h0;
      bus_size_out <= 2'h0;
      bus_buf_out <= 1'b0;
      bus_lock_out <= 1'b0;
      wb_drain_out <= 1'b0;
      ctl.fill_adv <= 1'b0;
      ctl.mdone <= 1'b0;
      ctl.hit <= 1'b0;
    end else begin
      core_done_out <= 1'b0;
      ctl.fill_adv <= 1'b0;
      ctl.mdone <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (ctl.mgo) begin
            ctl.mdone <= 1'b1;
            state <= ST_MDONE;
          end else if (core_req_in) begin
            a <= core_addr_in;
            wd <= core_wdata_in;
            sz <= core_size_in;
            wr <= core_write_in;
            sw <= core_swap_in;
            cen <= core_cacheable_in && ctl.enable;
            bf <= core_bufferable_in;
            irq_hold_out <= core_swap_in;
            st_hit <= lk_hit;
            lidx <= lk_idx;
            ctl.hit <= lk_hit;
            if (core_write_in && !core_swap_in) begin
              state <= ST_STORE;
            end else if (!(core_cacheable_in && ctl.enable) && core_swap_in) begin
              wb_drain_out <= 1'b1;
              state <= ST_DRAIN;
            end else if (!(core_cacheable_in && ctl.enable)) begin
              bus_req_out <= 1'b1;
              bus_write_out <= 1'b0;
              bus_addr_out <= core_addr_in;
              bus_size_out <= core_size_in;
              state <= ST_BUS_RD;
            end else if (lk_hit) begin
              core_rdata_out <= pick(data_q[{lk_seg, lk_idx, core_addr_in[4:2]}], core_addr_in[1:0], core_size_in);
              if (core_swap_in) begin
                state <= ST_STORE;
              end else begin
                core_done_out <= 1'b1;
                state <= ST_RESP;
              end
            end else begin
              lidx <= ctl.victim;
              cnt <= 3'h0;
              bus_req_out <= 1'b1;
              bus_write_out <= 1'b0;
              bus_addr_out <= {core_addr_in[31:5], 5'h0};
              bus_size_out <= SZ_WORD;
              state <= ST_FILL;
            end
          end
        end
        ST_DRAIN: begin
          if (wb_empty_in) begin
            wb_drain_out <= 1'b0;
            bus_req_out <= 1'b1;
            bus_write_out <= 1'b0;
            bus_addr_out <= a;
            bus_size_out <= sz;
            bus_lock_out <= 1'b1;
            state <= ST_BUS_RD;
          end
        end
        ST_BUS_RD: begin
          if (bus_ack_in) begin
            bus_req_out <= 1'b0;
            core_rdata_out <= pick(bus_rdata_in, a[1:0], sz);
            if (sw) begin
              state <= ST_STORE;
            end else begin
              core_done_out <= 1'b1;
              state <= ST_RESP;
            end
          end
        end
        ST_FILL: begin
          if (bus_ack_in) begin
            cnt <= cnt + 3'h1;
            bus_addr_out[4:2] <= cnt + 3'h1;
            if (cnt == a[4:2]) core_rdata_out <= pick(bus_rdata_in, a[1:0], sz);
            if (cnt == `DCL_LAST_WORD) begin
              bus_req_out <= 1'b0;
              ctl.fill_adv <= 1'b1;
              st_hit <= 1'b1;
              if (sw) begin
                state <= ST_STORE;
              end else begin
                core_done_out <= 1'b1;
                state <= ST_RESP;
              end
            end
          end
        end
        ST_STORE: begin
          bus_req_out <= 1'b1;
          bus_write_out <= 1'b1;
          bus_addr_out <= a;
          bus_wdata_out <= wd;
          bus_size_out <= sz;
          bus_buf_out <= bf && !(sw && !cen);
          state <= ST_BUS_WR;
        end
        ST_BUS_WR: begin
          if (bus_ack_in) begin
            bus_req_out <= 1'b0;
            bus_write_out <= 1'b0;
            bus_lock_out <= 1'b0;
            core_done_out <= 1'b1;
            state <= ST_RESP;
          end
        end
        ST_RESP: begin
          irq_hold_out <= 1'b0;
          state <= ST_IDLE;
        end
        ST_MDONE: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Line state. No dirty tracking: stores write through, so a clean has nothing to flush
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      valid_q <= 512'h0;
    end else if (mt) begin
      unique case (ctl.mop)
        OP_INV_ALL: valid_q <= 512'h0;
        OP_INV_ADR, OP_CLI_ADR: if (lk_hit) valid_q[{lk_seg, lk_idx}] <= 1'b0;
        OP_CLI_IDX: valid_q[{ctl.idx_seg, ctl.idx_val}] <= 1'b0;
        default: valid_q <= valid_q;
      endcase
    end else if (state == ST_IDLE && core_req_in && core_cacheable_in && ctl.enable && !lk_hit &&
                 !(core_write_in && !core_swap_in)) begin
      valid_q[{core_addr_in[7:5], ctl.victim}] <= 1'b0;
    end else if (fill_end) begin
      valid_q[{a[7:5], lidx}] <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (fill_end) tag_q[{a[7:5], lidx}] <= a[31:8];
  end
  always_ff @(posedge clk_sys_in) begin
    if (state == ST_FILL && bus_ack_in) data_q[{a[7:5], lidx, cnt}] <= bus_rdata_in;
    else if (state == ST_STORE && st_hit)
      data_q[{a[7:5], lidx, a[4:2]}] <= merge(data_q[{a[7:5], lidx, a[4:2]}], wd, a[1:0], sz);
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);
  a_cached_swap_unlocked: assert property (state != ST_IDLE && sw && cen |-> !bus_lock_out)
    else $error("bus lock raised during cached swap");
  a_swap_irq_hold: assert property (state == ST_STORE && sw |-> irq_hold_out ##1 irq_hold_out)
    else $error("interrupts not held between swap halves");
  a_locked_read_first: assert property ($rose(bus_lock_out) |-> bus_req_out && !bus_write_out && !wb_drain_out)
    else $error("locked swap did not start with a read");
  a_nc_write_unbuf: assert property (bus_req_out && bus_write_out && bus_lock_out |-> !bus_buf_out)
    else $error("uncached swap write marked bufferable");
  a_nc_swap_lock: assert property (state == ST_STORE && sw && !cen |=> bus_lock_out && bus_req_out)
    else $error("uncached swap write without bus lock");
  a_fill_sets_line: assert property (fill_end |=> valid_q[{a[7:5], lidx}] && tag_q[{a[7:5], lidx}] == a[31:8])
    else $error("linefill did not install tag and valid");
  a_fill_address: assert property (state == ST_FILL && bus_req_out |-> bus_addr_out[4:2] == cnt &&
                                    bus_addr_out[31:5] == a[31:5])
    else $error("linefill address out of sequence");
  a_victim_range: assert property (ctl.victim >= ctl.base)
    else $error("victim below lockdown base");
  a_hit_match: assert property (state == ST_IDLE && core_req_in && !ctl.mgo && lk_hit |->
                                valid_q[{lk_seg, lk_idx}] && tag_q[{lk_seg, lk_idx}] == core_addr_in[31:8])
    else $error("hit reported without matching tag");
  a_fill_length: assert property ($rose(state == ST_FILL) |-> (state == ST_FILL) [*8])
    else $error("linefill shorter than eight beats");
  c_linefill: cover property (fill_end);
  c_nc_swap: cover property (bus_lock_out && bus_write_out && bus_ack_in);
  c_cached_swap: cover property (state == ST_STORE && sw && cen);
  c_maint_idx: cover property (ctl.idx_set);
endmodule
`default_nettype wire

// [tb/dcl_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// System bus and write buffer
module dcl_bus_model (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic bus_req_in,
  input wire logic bus_write_in,
  input wire logic bus_buf_in,
  input wire logic [31:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  input wire logic wb_drain_in,
  output logic bus_ack_out,
  output logic [31:0] bus_rdata_out,
  output logic wb_empty_out
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] ky;
  int wait_n;
  int drain_n;
  assign ky = {bus_addr_in[31:2], 2'h0};
  // Lone master here, so a locked read/write pair is never split
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_ack_out <= 1'h0;
      bus_rdata_out <= 32'h0;
      wb_empty_out <= 1'h1;
      wait_n = 0;
      drain_n = 0;
    end else begin
      bus_ack_out <= 1'h0;
      // Idle data toggles so a stale read never looks right
      bus_rdata_out <= ~bus_rdata_out;
      if (bus_req_in && !bus_ack_out && wait_n > 0) begin
        wait_n = wait_n - 1;
      end else if (bus_req_in && !bus_ack_out) begin
        wait_n = $urandom_range(3, 0);
        bus_ack_out <= 1'h1;
        bus_rdata_out <= mem.exists(ky) ? mem[ky] : {ky[15:0], ~ky[15:0]};
        if (bus_write_in) mem[ky] = bus_wdata_in;
        if (bus_write_in && bus_buf_in) wb_empty_out <= 1'h0;
      end
      drain_n = wb_drain_in ? drain_n + 1 : 0;
      // Draining takes time, so the device must really wait
      if (drain_n > 2) wb_empty_out <= 1'h1;
    end
  end
endmodule
`default_nettype wire

// [tb/segmented_data_cache_lockdown_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dcl_regs.svh"
module segmented_data_cache_lockdown_test;
  logic clk_sys_in, resetn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, er;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, core_addr_in, core_wdata_in, core_rdata_out, rd, a0;
  logic [31:0] bus_addr_out, bus_wdata_out, bus_rdata_in;
  logic core_req_in, core_write_in, core_swap_in, core_cacheable_in, core_bufferable_in, core_done_out;
  logic irq_hold_out, bus_req_out, bus_write_out, bus_buf_out, bus_lock_out, bus_ack_in, wb_drain_out, wb_empty_in;
  logic [1:0] core_size_in, bus_size_out;
  logic [66:0] seen_q[$], exp_q[$];
  logic [31:0] mm [logic [31:0]];
  int miscompares, checks, base, robin, saw_irq, saw_drain, t0, s2;
  int tg[8][64], vl[8][64], ptr[8];
  int ops[6] = '{2, 3, 4, 5, 6, 1};
  dcl_cache dcl_cache_i (.clk_sys_in, .resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .pready_out, .prdata_out, .pslverr_out, .core_req_in, .core_addr_in, .core_write_in, .core_swap_in,
    .core_size_in, .core_wdata_in, .core_cacheable_in, .core_bufferable_in, .core_done_out, .core_rdata_out,
    .irq_hold_out, .bus_req_out, .bus_write_out, .bus_addr_out, .bus_wdata_out, .bus_size_out, .bus_buf_out,
    .bus_lock_out, .bus_ack_in, .bus_rdata_in, .wb_drain_out, .wb_empty_in);
  dcl_bus_model dcl_bus_model_i (.clk_sys_in, .resetn_in, .bus_req_in(bus_req_out), .bus_write_in(bus_write_out),
    .bus_buf_in(bus_buf_out), .bus_addr_in(bus_addr_out), .bus_wdata_in(bus_wdata_out), .wb_drain_in(wb_drain_out),
    .bus_ack_out(bus_ack_in), .bus_rdata_out(bus_rdata_in), .wb_empty_out(wb_empty_in));
  initial begin
    clk_sys_in = 1'h0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // ==========================================
  // Monitor and helpers
  always @(posedge clk_sys_in) begin
    if (bus_req_out && bus_ack_in) seen_q.push_back({bus_write_out, bus_lock_out, bus_buf_out & bus_write_out,
      bus_addr_out[31:2], 2'h0, bus_wdata_out & {32{bus_write_out}}});
    if (irq_hold_out) saw_irq = 1;
    if (wb_drain_out) saw_drain = 1;
  end
  task automatic chk(input string nm, input logic [66:0] seen, input logic [66:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'h1;
    penable_in <= 1'h0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'h1;
    do begin
      @(posedge clk_sys_in);
    end while (pready_out !== 1'h1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask
  task automatic setc(input int r);
    apb(1'h1, `DCL_OFF_CTRL, (r << `DCL_CTRL_ORDER) | 1);
    robin = r;
  endtask
  task automatic setv(input int v);
    apb(1'h1, `DCL_OFF_VICT, v << `DCL_VICT_LSB);
    base = v;
    foreach (ptr[s]) ptr[s] = v;
  endtask
  function automatic int mfind(input logic [31:0] a);
    mfind = -1;
    for (int i = 0; i < 64; i++) if (vl[a[7:5]][i] != 0 && tg[a[7:5]][i] == a[31:8]) mfind = i;
  endfunction
  // Model predicts bus traffic and data, then one core request runs
  task automatic core(input logic w, input logic sw, input logic [31:0] a, input logic [1:0] sz,
      input logic [31:0] d, input logic c, input logic b);
    int seg, idx;
    logic [31:0] ky, old, ex;
    seg = a[7:5];
    ky = {a[31:2], 2'h0};
    old = mm.exists(ky) ? mm[ky] : {ky[15:0], ~ky[15:0]};
    ex = (sz == 2'h2) ? old : (sz == 2'h1) ? {16'h0, old[a[1] * 16 +: 16]} : {24'h0, old[a[1:0] * 8 +: 8]};
    seen_q.delete();
    exp_q.delete();
    saw_irq = 0;
    saw_drain = 0;
    if (!w && c && mfind(a) < 0) begin
      for (int k = 0; k < 8; k++) exp_q.push_back({3'h0, a[31:5], k[2:0], 34'h0});
      idx = robin ? ptr[seg] : base;
      if (robin) ptr[seg] = (idx == 63) ? base : idx + 1;
      tg[seg][idx] = a[31:8];
      vl[seg][idx] = 1;
    end
    if (!w && !c) exp_q.push_back({1'h0, sw, 1'h0, a[31:2], 34'h0});
    if (w || sw) exp_q.push_back({1'h1, sw && !c, b && !(sw && !c), a[31:2], 2'h0, d});
    if (w || sw) mm[ky] = d;
    @(posedge clk_sys_in);
    core_req_in <= 1'h1;
    core_write_in <= w;
    core_swap_in <= sw;
    core_addr_in <= a;
    core_size_in <= sz;
    core_wdata_in <= d;
    core_cacheable_in <= c;
    core_bufferable_in <= b;
    do begin
      @(posedge clk_sys_in);
    end while (core_done_out !== 1'h1);
    core_req_in <= 1'h0;
    if (!w) chk("load data", 67'(core_rdata_out), 67'(ex));
    chk("bus count", 67'(seen_q.size()), 67'(exp_q.size()));
    foreach (exp_q[i]) chk("bus xfer", seen_q[i], exp_q[i]);
    if (exp_q.size() > 0) chk("bus size", 67'(bus_size_out), 67'((w || sw || !c) ? sz : 2'h2));
    if (sw) chk("irq hold", 67'(saw_irq), 67'h1);
    if (sw && !c) chk("drain", 67'(saw_drain), 67'h1);
  endtask
  task automatic ld(input logic [31:0] a);
    core(1'h0, 1'h0, a, 2'h2, 32'h0, 1'h1, 1'h0);
  endtask
  task automatic mop(input int op, input logic [31:0] arg);
    apb(1'h1, `DCL_OFF_MARG, arg);
    apb(1'h1, `DCL_OFF_MCMD, op);
    do begin
      apb(1'h0, `DCL_OFF_STAT, 32'h0);
    end while (rd[0] !== 1'h0);
    if (op == 1) foreach (vl[s, i]) vl[s][i] = 0;
    if (op == 2 || op == 4) foreach (vl[s, i]) if (s == arg[7:5] && tg[s][i] == arg[31:8]) vl[s][i] = 0;
    if (op == 6) vl[arg[7:5]][arg[31:26]] = 0;
    if (op > 4) ptr[arg[7:5]] = arg[31:26];
  endtask
  // ==========================================
  // Watchdog sized well above the expected run
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    miscompares++;
    final_report;
  end
  // ==========================================
  // Main sequence
  initial begin
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, core_req_in, core_write_in, core_swap_in} = '0;
    {core_addr_in, core_wdata_in, core_size_in, core_cacheable_in, core_bufferable_in} = '0;
    miscompares = 0;
    checks = 0;
    resetn_in = 1'h0;
    void'($urandom(44));
    repeat (2) @(posedge clk_sys_in);
    resetn_in <= 1'h1;
    apb(1'h0, `DCL_OFF_CTRL, 32'h0);
    chk("ctrl reset", 67'(rd), 67'h0);
    apb(1'h0, 8'h14, 32'h0);
    chk("unmapped", 67'(er), 67'h1);
    setc(1);
    setv(62);
    apb(1'h0, `DCL_OFF_VICT, 32'h0);
    chk("base field", 67'(rd[31:26]), 67'd62);
    t0 = $urandom_range(9999, 16);
    // Two free lines per segment: fills wrap 63 to base, per segment
    for (int k = 0; k < 40; k++) begin
      s2 = $urandom_range(2, 0);
      a0 = {t0[23:0] + 24'($urandom_range(2, 0)), 3'($urandom_range(1, 0)), 3'($urandom_range(7, 0)), 2'h0};
      a0[1:0] = (s2 == 0) ? 2'($urandom_range(3, 0)) : (s2 == 1) ? {1'($urandom_range(1, 0)), 1'h0} : 2'h0;
      core(s2 == 2 && $urandom_range(3, 0) == 0, 1'h0, a0, 2'(s2), $urandom, $urandom_range(3, 0) != 0,
        1'($urandom));
    end
    setv(0);
    a0 = {t0[23:0] + 24'h9, 8'h40};
    ld(a0);
    setv(1);
    setc(0);
    for (int k = 0; k < 8; k++) ld({t0[23:0] + 24'(k + 20), 8'h44});
    ld(a0);
    mop(1, 32'h0);
    setc(1);
    setv(0);
    foreach (ops[i]) begin
      a0 = {t0[23:0] + 24'(i + 40), 8'h6c};
      ld(a0);
      mop(ops[i], ops[i] > 4 ? {6'(mfind(a0)), 18'h0, a0[7:5], 5'h0} : a0);
      ld(a0);
      ld(a0 + 32'h8000);
      ld(a0);
    end
    a0 = {t0[23:0], 8'h84};
    core(1'h1, 1'h0, a0, 2'h2, $urandom, 1'h1, 1'h1);
    core(1'h0, 1'h1, a0, 2'h2, $urandom, 1'h1, 1'h1);
    ld(a0);
    core(1'h0, 1'h1, a0 + 32'h400, 2'h2, $urandom, 1'h0, 1'h1);
    core(1'h0, 1'h1, a0, 2'h2, $urandom, 1'h0, 1'h1);
    ld(a0);
    final_report;
  end
endmodule
`default_nettype wire
